// [verilog/afr_ctrl.sv]
`timescale 1ns/10ps
`default_nettype none
// How it works
// - channel writes never clear the done flag
// - a conversion in flight may still finish on the old channel
// - start within 1 us of comparator enable marks first result suspect
// - start with comparator disabled marks first result suspect
// - mode, channel or port config writes outside the completion cycle leave results undefined
module afr_ctrl
(
    input wire logic CLK_SYS,
    input wire logic SYS_RST,
    input wire logic COMPARATOR_ENABLE_BIT,
    input wire logic CONVERSION_START_BIT,
    input wire logic CH_WR,
    input wire logic [afr_pkg::CH_W-1:0] CH_WDATA,
    input wire logic MODE_WR,
    input wire logic [afr_pkg::MODE_W-1:0] MODE_WDATA,
    input wire logic PCFG_WR,
    input wire logic [afr_pkg::PCFG_W-1:0] PCFG_WDATA,
    input wire logic FLAG_CLR,
    input wire logic [afr_pkg::RES_W-1:0] SAR_DATA,
    output logic CONVERSION_DONE_FLAG,
    output logic CONVERSION_END_IRQ,
    output logic FIRST_SUSPECT,
    output logic BUSY,
    output logic [afr_pkg::CH_W-1:0] CHANNEL_SELECT_REG,
    output logic [afr_pkg::CH_W-1:0] CONV_CHANNEL,
    output logic [afr_pkg::MODE_W-1:0] CONVERTER_MODE_REG,
    output logic [afr_pkg::PCFG_W-1:0] PORT_CONFIG_REG,
    output logic [afr_pkg::RES_W-1:0] RESULT_REG,
    output logic [7:0] RESULT_HIGH_REG
);
    import afr_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    afr_state_t state;
    afr_state_t next_state;
    logic [5:0] settle;
    logic [5:0] conv;
    logic start_q;
    logic suspect_run;

    wire logic start_rise = CONVERSION_START_BIT & ~start_q;
    wire logic settled = (settle >= SETTLE_CNT);
    wire logic cfg_wr = MODE_WR | CH_WR | PCFG_WR;
    // a channel write mid-run restarts; only in the completion cycle does the old-channel conversion finish
    wire logic conv_end = (state == AFR_CONV) && (conv == CONV_CNT - 6'h01);
    wire logic restart = CH_WR && (state == AFR_CONV) && !conv_end;

    always_comb begin
        next_state = state;
        unique case (state)
            AFR_IDLE: if (start_rise) next_state = AFR_CONV;
            AFR_CONV: if (!CONVERSION_START_BIT) next_state = AFR_IDLE;
                else if (conv_end) next_state = AFR_DONE;
            AFR_DONE: next_state = CONVERSION_START_BIT ? AFR_CONV : AFR_IDLE;
            default: next_state = AFR_IDLE;
        endcase
    end

    // ------------------------------------------------------------
    // sequencing
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            state <= AFR_IDLE;
            start_q <= 1'b0;
            settle <= 6'h00;
            conv <= 6'h00;
        end else begin
            state <= next_state;
            start_q <= CONVERSION_START_BIT;
            // settle counts time since comparator enable
            if (!COMPARATOR_ENABLE_BIT) settle <= 6'h00;
            else if (!settled) settle <= settle + 6'h01;
            if (next_state != AFR_CONV || state != AFR_CONV || restart) conv <= 6'h00;
            else conv <= conv + 6'h01;
        end
    end

    // ------------------------------------------------------------
    // first-result quality
    // ------------------------------------------------------------
    // only tracked, not corrected: software drops the first result
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            suspect_run <= 1'b0;
            FIRST_SUSPECT <= 1'b0;
        end else begin
            if (start_rise && state == AFR_IDLE)
                suspect_run <= !COMPARATOR_ENABLE_BIT || !settled;
            else if (conv_end)
                suspect_run <= 1'b0;
            if (conv_end) FIRST_SUSPECT <= suspect_run;
        end
    end

    // ------------------------------------------------------------
    // config registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            CHANNEL_SELECT_REG <= CH_RST;
            CONV_CHANNEL <= CH_RST;
            CONVERTER_MODE_REG <= MODE_RST;
            PORT_CONFIG_REG <= PCFG_RST;
            BUSY <= 1'b0;
        end else begin
            if (CH_WR) CHANNEL_SELECT_REG <= CH_WDATA;
            if (MODE_WR) CONVERTER_MODE_REG <= MODE_WDATA;
            if (PCFG_WR) PORT_CONFIG_REG <= PCFG_WDATA;
            // channel latched at conversion start so completion reports the old one
            if (next_state == AFR_CONV && (state != AFR_CONV || restart || conv_end))
                CONV_CHANNEL <= CH_WR ? CH_WDATA : CHANNEL_SELECT_REG;
            BUSY <= (next_state == AFR_CONV);
        end
    end

    // ------------------------------------------------------------
    // flag and irq
    // ------------------------------------------------------------
    always_ff @(posedge CLK_SYS) begin
        if (SYS_RST) begin
            CONVERSION_DONE_FLAG <= 1'b0;
            CONVERSION_END_IRQ <= 1'b0;
        end else begin
            // set beats clear; channel writes do not touch the flag
            if (conv_end) CONVERSION_DONE_FLAG <= 1'b1;
            else if (FLAG_CLR) CONVERSION_DONE_FLAG <= 1'b0;
            CONVERSION_END_IRQ <= conv_end;
        end
    end

    afr_result_mem u_mem (
        .clk(CLK_SYS),
        .rst(SYS_RST),
        .load(conv_end),
        .wdata(SAR_DATA),
        .spoil(cfg_wr && !conv_end),
        .rdata(RESULT_REG),
        .rdata_high(RESULT_HIGH_REG)
    );

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    sequence s_done;
        conv_end;
    endsequence
    chk_flag_on_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_done |=> CONVERSION_DONE_FLAG && CONVERSION_END_IRQ && RESULT_REG == $past(SAR_DATA))
        else $error("done did not load result, flag and irq");
    chk_chan_keeps_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        CH_WR && !FLAG_CLR && CONVERSION_DONE_FLAG |=> CONVERSION_DONE_FLAG)
        else $error("channel write cleared flag");
    chk_old_chan_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        CH_WR && conv_end |=> CONVERSION_DONE_FLAG && CONVERSION_END_IRQ)
        else $error("old channel result lost");
    chk_clear_works: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        FLAG_CLR && !conv_end |=> !CONVERSION_DONE_FLAG)
        else $error("flag clear ignored");
    chk_early_start: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        start_rise && state == AFR_IDLE && COMPARATOR_ENABLE_BIT && !settled |=> suspect_run)
        else $error("early start not marked");
    chk_cold_start: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        start_rise && state == AFR_IDLE && !COMPARATOR_ENABLE_BIT |=> suspect_run)
        else $error("start without comparator not marked");
    chk_spoil_result: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        cfg_wr && !conv_end |=> RESULT_REG != $past(RESULT_REG))
        else $error("config write left result intact");
    chk_irq_pulse: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        CONVERSION_END_IRQ |=> !CONVERSION_END_IRQ)
        else $error("irq longer than one cycle");

    // ------------------------------------------------------------
    // channel, quality, flag, irq and result-store checks
    // ------------------------------------------------------------
    // internal counters are watched so a broken decoder fails here first
    sequence s_idle_start;
        start_rise && state == AFR_IDLE;
    endsequence
    sequence s_mid_chan;
        CH_WR && CONVERSION_START_BIT && state == AFR_CONV && !conv_end;
    endsequence

    chk_restart_chan: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_mid_chan |=> CONV_CHANNEL == $past(CH_WDATA) && conv == 6'h00)
        else $error("mid-run channel write did not restart");
    chk_done_chan_kept: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_done ##0 CH_WR |=> CONV_CHANNEL == $past(CONV_CHANNEL))
        else $error("completion channel lost on channel write");
    chk_no_spoil_load: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_done ##0 CH_WR |=> RESULT_REG == $past(SAR_DATA))
        else $error("old channel result not stored");
    chk_suspect_clean: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_idle_start ##0 (COMPARATOR_ENABLE_BIT && settled) |=> !suspect_run)
        else $error("settled start marked suspect");
    chk_suspect_out: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_done |=> FIRST_SUSPECT == $past(suspect_run))
        else $error("suspect mark not reported at completion");
    chk_set_wins: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        s_done ##0 FLAG_CLR |=> CONVERSION_DONE_FLAG)
        else $error("clear beat completion");
    chk_cfg_no_flag: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        cfg_wr && !conv_end && !FLAG_CLR |=> CONVERSION_DONE_FLAG == $past(CONVERSION_DONE_FLAG))
        else $error("config write moved done flag");
    chk_flag_sticky: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        CONVERSION_DONE_FLAG && !FLAG_CLR |=> CONVERSION_DONE_FLAG)
        else $error("done flag dropped without clear");
    chk_flag_rise_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !conv_end && !CONVERSION_DONE_FLAG |=> !CONVERSION_DONE_FLAG)
        else $error("done flag set without completion");
    chk_irq_only_done: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        !conv_end |=> !CONVERSION_END_IRQ)
        else $error("irq without completion");
    chk_high_pairs: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        RESULT_HIGH_REG == RESULT_REG[RES_W-1:RES_W-8])
        else $error("high byte out of step with result");
    chk_hi_spoil: assert property (@(posedge CLK_SYS) disable iff (SYS_RST)
        cfg_wr && !conv_end |=> RESULT_HIGH_REG != $past(RESULT_HIGH_REG))
        else $error("config write left high byte intact");
endmodule : afr_ctrl
`default_nettype wire

// [verilog/afr_pkg.sv]
package afr_pkg;
    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int RES_W = 10;
    localparam int CH_W = 3;
    localparam int MODE_W = 8;
    localparam int PCFG_W = 4;
    // ------------------------------------------------------------
    // timing
    // ------------------------------------------------------------
    localparam int CLK_HZ = 50_000_000;
    localparam int SETTLE_NS = 1000;
    localparam int SETTLE_CYC = (SETTLE_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
    localparam int CONV_CYC = 22;
    localparam logic [5:0] SETTLE_CNT = 6'(SETTLE_CYC);
    localparam logic [5:0] CONV_CNT = 6'(CONV_CYC);
    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [RES_W-1:0] RES_RST = 10'h000;
    localparam logic [CH_W-1:0] CH_RST = 3'h0;
    localparam logic [MODE_W-1:0] MODE_RST = 8'h00;
    localparam logic [PCFG_W-1:0] PCFG_RST = 4'h0;
    typedef enum logic [1:0] {AFR_IDLE, AFR_CONV, AFR_DONE} afr_state_t;
endpackage : afr_pkg

// [verilog/afr_result_mem.sv]
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// result store: full word and high byte, registered outputs
// ------------------------------------------------------------
module afr_result_mem
(
    input wire logic clk,
    input wire logic rst,
    input wire logic load,
    input wire logic [afr_pkg::RES_W-1:0] wdata,
    input wire logic spoil,
    output logic [afr_pkg::RES_W-1:0] rdata,
    output logic [7:0] rdata_high
);
    import afr_pkg::*;

    // spoil models undefined contents after a config write
    wire logic [RES_W-1:0] spoil_val = ~rdata;
    always_ff @(posedge clk) begin
        if (rst) begin
            rdata <= RES_RST;
            rdata_high <= 8'h00;
        end else if (load) begin
            rdata <= wdata;
            rdata_high <= wdata[RES_W-1:RES_W-8];
        end else if (spoil) begin
            rdata <= spoil_val;
            rdata_high <= spoil_val[RES_W-1:RES_W-8];
        end
    end
endmodule : afr_result_mem
`default_nettype wire

// [tb/tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin bad_count++; \
    $display("BAD %s expected %h seen %h", nm, exp, got); end end
module tb_top;
    import afr_pkg::*;
    logic CLK_SYS = 0, SYS_RST = 1, COMP_EN = 0, START = 0, CH_WR = 0, MODE_WR = 0;
    logic PCFG_WR = 0, FLAG_CLR = 0;
    logic [CH_W-1:0] CH_WDATA = 3'h0;
    logic [MODE_W-1:0] MODE_WDATA = 8'h00;
    logic [PCFG_W-1:0] PCFG_WDATA = 4'h0;
    logic [RES_W-1:0] SAR_DATA = 10'h000, exp_res;
    logic DONE, IRQ, SUSPECT, BUSY;
    logic [CH_W-1:0] CH_REG, CONV_CH;
    logic [MODE_W-1:0] MODE_REG;
    logic [PCFG_W-1:0] PCFG_REG;
    logic [RES_W-1:0] RES;
    logic [7:0] RES_HI;
    int bad_count = 0, tests_run = 0;
    always #10 CLK_SYS = ~CLK_SYS;
    afr_ctrl uut (.CLK_SYS(CLK_SYS), .SYS_RST(SYS_RST), .COMPARATOR_ENABLE_BIT(COMP_EN),
        .CONVERSION_START_BIT(START), .CH_WR(CH_WR), .CH_WDATA(CH_WDATA), .MODE_WR(MODE_WR),
        .MODE_WDATA(MODE_WDATA), .PCFG_WR(PCFG_WR), .PCFG_WDATA(PCFG_WDATA),
        .FLAG_CLR(FLAG_CLR), .SAR_DATA(SAR_DATA), .CONVERSION_DONE_FLAG(DONE),
        .CONVERSION_END_IRQ(IRQ), .FIRST_SUSPECT(SUSPECT), .BUSY(BUSY),
        .CHANNEL_SELECT_REG(CH_REG), .CONV_CHANNEL(CONV_CH), .CONVERTER_MODE_REG(MODE_REG),
        .PORT_CONFIG_REG(PCFG_REG), .RESULT_REG(RES), .RESULT_HIGH_REG(RES_HI));
    // ------------------------------------------------------------
    // access tasks
    // ------------------------------------------------------------
    task tick;
        @(posedge CLK_SYS);
        #1;
    endtask : tick
    task end_of_test;
        if (bad_count == 0 && tests_run > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    // hold start until the completion pulse, bounded so a dead converter is reported
    task run_conv(input logic [RES_W-1:0] val, input logic exp_sus);
        int n;
        SAR_DATA = val;
        START = 1;
        n = 0;
        tick;
        tick;
        `CHK("busy", 1'b1, BUSY)
        while (IRQ !== 1'b1 && n < 100) begin
            tick;
            n++;
        end
        `CHK("irq", 1'b1, IRQ)
        `CHK("done", 1'b1, DONE)
        `CHK("result", val, RES)
        `CHK("result_high", val[9:2], RES_HI)
        `CHK("suspect", exp_sus, SUSPECT)
        START = 0; // start low returns to idle; a new run needs a fresh start edge, not a flag clear
        tick;
        `CHK("irq_pulse", 1'b0, IRQ)
        exp_res = val;
    endtask : run_conv
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        #1;
        repeat (2) tick;
        SYS_RST = 0;
        `CHK("done_rst", 1'b0, DONE)
        `CHK("res_rst", RES_RST, RES)
        COMP_EN = 1;
        repeat (SETTLE_CYC + 10) tick;
        run_conv(10'h2b5, 1'b0);
        `CHK("res_before_wr", exp_res, RES)
        CH_WR = 1;
        CH_WDATA = 3'h5;
        tick;
        CH_WR = 0;
        `CHK("done_after_ch", 1'b1, DONE)
        `CHK("ch_reg", 3'h5, CH_REG)
        exp_res = ~exp_res; // write not in completion cycle spoils result
        `CHK("res_ch_wr", exp_res, RES)
        MODE_WR = 1;
        MODE_WDATA = 8'ha5;
        tick;
        MODE_WR = 0;
        exp_res = ~exp_res;
        `CHK("res_mode_wr", exp_res, RES)
        `CHK("mode_reg", 8'ha5, MODE_REG)
        PCFG_WR = 1;
        PCFG_WDATA = 4'h9;
        tick;
        PCFG_WR = 0;
        exp_res = ~exp_res;
        `CHK("res_pcfg_wr", exp_res, RES)
        `CHK("res_hi_pcfg", exp_res[9:2], RES_HI)
        `CHK("pcfg_reg", 4'h9, PCFG_REG)
        `CHK("done_still", 1'b1, DONE)
        FLAG_CLR = 1;
        tick;
        FLAG_CLR = 0;
        `CHK("done_clr", 1'b0, DONE)
        COMP_EN = 0;
        run_conv(10'h1c3, 1'b1);
        `CHK("conv_ch", 3'h5, CONV_CH)
        FLAG_CLR = 1;
        tick;
        FLAG_CLR = 0;
        COMP_EN = 1;
        repeat (10) tick;
        run_conv(10'h36a, 1'b1);
        FLAG_CLR = 1;
        tick;
        FLAG_CLR = 0;
        repeat (SETTLE_CYC) tick;
        // channel write and clear both land in the completion cycle
        SAR_DATA = 10'h0f0;
        START = 1;
        repeat (CONV_CYC) tick;
        CH_WR = 1;
        CH_WDATA = 3'h2;
        FLAG_CLR = 1;
        tick;
        CH_WR = 0;
        FLAG_CLR = 0;
        `CHK("irq_old_ch", 1'b1, IRQ)
        `CHK("done_set_wins", 1'b1, DONE)
        `CHK("res_old_ch", 10'h0f0, RES)
        `CHK("conv_ch_old", 3'h5, CONV_CH)
        `CHK("suspect_settled", 1'b0, SUSPECT)
        SAR_DATA = 10'h155;
        tick;
        `CHK("conv_ch_next", 3'h2, CONV_CH)
        // channel write mid-run restarts on the new channel
        repeat (4) tick;
        CH_WR = 1;
        CH_WDATA = 3'h6;
        tick;
        CH_WR = 0;
        `CHK("conv_ch_restart", 3'h6, CONV_CH)
        `CHK("done_mid_ch", 1'b1, DONE)
        `CHK("res_mid_ch", ~10'h0f0, RES)
        repeat (CONV_CYC - 1) tick;
        `CHK("irq_early", 1'b0, IRQ)
        tick;
        `CHK("irq_restart", 1'b1, IRQ)
        `CHK("res_restart", 10'h155, RES)
        START = 0;
        tick;
        // reset in mid-run: every output back to its reset value
        START = 1;
        repeat (2) tick;
        `CHK("busy_pre_rst", 1'b1, BUSY)
        SYS_RST = 1;
        START = 0;
        repeat (2) tick;
        SYS_RST = 0;
        `CHK("busy_rst", 1'b0, BUSY)
        `CHK("done_rst2", 1'b0, DONE)
        `CHK("irq_rst", 1'b0, IRQ)
        `CHK("suspect_rst", 1'b0, SUSPECT)
        `CHK("res_rst2", RES_RST, RES)
        `CHK("res_hi_rst", 8'h00, RES_HI)
        `CHK("ch_rst", CH_RST, CH_REG)
        `CHK("conv_ch_rst", CH_RST, CONV_CH)
        `CHK("mode_rst", MODE_RST, MODE_REG)
        `CHK("pcfg_rst", PCFG_RST, PCFG_REG)
        tick;
        `CHK("idle_after_rst", 1'b0, BUSY)
        end_of_test;
    end
    initial begin
        #(20 * 2000);
        bad_count++;
        end_of_test;
    end
endmodule : tb_top
`default_nettype wire
